// >>> design/eesfr_pkg.sv
// Constants for the EEPROM special function register interface.
// Assumes an 8-bit direct address space shared with the core's other SFRs.
package eesfr_pkg;
    // ------------------------------------------------------------
    // Direct addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MEM_ADDR_LOW     = 8'hF2;
    localparam logic [7:0] ADDR_MEM_ADDR_HIGH    = 8'hF3;
    localparam logic [7:0] ADDR_MEM_DATA         = 8'hF4;
    localparam logic [7:0] ADDR_MEM_WRITE_TIMING = 8'hF5;
    localparam logic [7:0] ADDR_MEM_CONTROL      = 8'hF6;
    localparam int         NUM_MEM_REGS          = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_MEM_ADDR_LOW     = 8'h00;
    localparam logic [7:0] RST_MEM_ADDR_HIGH    = 8'h80;
    localparam logic [7:0] RST_MEM_DATA         = 8'h00;
    localparam logic [7:0] RST_MEM_WRITE_TIMING = 8'h08;
    localparam logic [7:0] RST_MEM_CONTROL      = 8'h00;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int BIT_FORCED_IRQ_FLAG  = 7;
    localparam int BIT_MEM_IRQ_ENABLE   = 6;
    localparam int BIT_ERASE_WRITE_BUSY = 5;
    localparam int BIT_CTRL_UNUSED      = 4;
    localparam int OP_SELECT_MSB        = 3;
    localparam int OP_SELECT_WIDTH      = 4;
    localparam int ROW_OFFSET_BITS      = 3;

    // Bit-addressable SFRs sit on addresses whose low three bits are zero
    localparam int BIT_POS_WIDTH = 3;

    typedef enum logic [3:0] {
        OP_BYTE_MODE   = 4'b0000,
        OP_BLOCK_ERASE = 4'b1010,
        OP_ROW_ERASE   = 4'b1100
    } eesfr_op_t;
endpackage

// >>> design/eesfr_top.sv
// EEPROM special function register bank between the core and the sequencer.
// Assumes the core presents single-cycle SFR byte and bit strobes, and the
// sequencer accepts one-cycle start/read pulses and pulses done when finished.
`timescale 1ns/10ps
module eesfr_top (
    input  wire logic       core_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       sfr_rd_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic [7:0] sfr_bit_addr_i,
    input  wire logic       sfr_bit_wr_i,
    input  wire logic       sfr_bit_wdata_i,
    output logic            sfr_bit_rdata_o,
    output logic            ee_start_o,
    output logic            ee_read_o,
    output eesfr_pkg::eesfr_op_t ee_op_o,
    output logic      [15:0] ee_addr_o,
    output logic      [7:0] ee_wdata_o,
    output logic      [7:0] ee_timing_o,
    input  wire logic       ee_done_i,
    input  wire logic       ee_rdata_valid_i,
    input  wire logic [7:0] ee_rdata_i,
    output logic            forced_irq_flag_o,
    output logic            mem_irq_enable_o
);
    import eesfr_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] mem_addr_low;
    logic [7:0] mem_addr_high;
    logic [7:0] mem_data;
    logic [7:0] mem_write_timing;
    logic       forced_irq_flag;
    logic       mem_irq_enable;
    logic       erase_write_busy;
    logic [3:0] op_select;
    logic       read_pending;

    logic       wr_addr_low;
    logic       wr_addr_high;
    logic       wr_data;
    logic       wr_timing;
    logic       wr_control;
    logic       legal_op;
    logic       launch;
    logic       issue_read;
    logic [7:0] ctrl_view;
    logic [7:0] next_rdata;

    // None of this bank's registers sit on an 8-aligned bit-addressable base
    // (F0H belongs to another unit), so bit strobes never reach them.
    logic [7:0] bit_base;
    logic       bit_hit;

    assign bit_base = {sfr_bit_addr_i[7:BIT_POS_WIDTH], 3'b000};
    assign bit_hit  = 1'b0 & (bit_base == ADDR_MEM_ADDR_LOW);

    assign wr_addr_low  = sfr_wr_i && (sfr_addr_i == ADDR_MEM_ADDR_LOW);
    assign wr_addr_high = sfr_wr_i && (sfr_addr_i == ADDR_MEM_ADDR_HIGH);
    assign wr_data      = sfr_wr_i && (sfr_addr_i == ADDR_MEM_DATA);
    assign wr_timing    = sfr_wr_i && (sfr_addr_i == ADDR_MEM_WRITE_TIMING);
    assign wr_control   = sfr_wr_i && (sfr_addr_i == ADDR_MEM_CONTROL);

    assign legal_op = (op_select == OP_BYTE_MODE) || (op_select == OP_ROW_ERASE) ||
                      (op_select == OP_BLOCK_ERASE);
    // Reserved op codes launch nothing
    assign launch     = wr_data && !erase_write_busy && legal_op;
    assign issue_read = read_pending && !erase_write_busy && !launch &&
                        (op_select == OP_BYTE_MODE);

    assign ctrl_view = {forced_irq_flag, mem_irq_enable, erase_write_busy, 1'b0, op_select};

    // ------------------------------------------------------------
    // Address, timing and control registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mem_addr_low  <= RST_MEM_ADDR_LOW;
            mem_addr_high <= RST_MEM_ADDR_HIGH;
        end else begin
            if (wr_addr_low) begin
                mem_addr_low <= sfr_wdata_i;
            end
            if (wr_addr_high) begin
                mem_addr_high <= sfr_wdata_i;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mem_write_timing <= RST_MEM_WRITE_TIMING;
        end else if (wr_timing) begin
            mem_write_timing <= sfr_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            forced_irq_flag <= RST_MEM_CONTROL[BIT_FORCED_IRQ_FLAG];
            mem_irq_enable  <= RST_MEM_CONTROL[BIT_MEM_IRQ_ENABLE];
            op_select       <= RST_MEM_CONTROL[OP_SELECT_MSB:0];
        end else if (wr_control) begin
            forced_irq_flag <= sfr_wdata_i[BIT_FORCED_IRQ_FLAG];
            mem_irq_enable  <= sfr_wdata_i[BIT_MEM_IRQ_ENABLE];
            op_select       <= sfr_wdata_i[OP_SELECT_MSB:0];
        end
    end

    // ------------------------------------------------------------
    // Busy flag: set by a launching data write, cleared only by the sequencer's done
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            erase_write_busy <= RST_MEM_CONTROL[BIT_ERASE_WRITE_BUSY];
        end else if (launch) begin
            erase_write_busy <= 1'b1;
        end else if (ee_done_i) begin
            erase_write_busy <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Data register and read refresh
    // ------------------------------------------------------------
    // A fresh read is owed after reset, an address or mode change, and the
    // end of an erase/write, so in byte mode the data register tracks the addressed byte.
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            read_pending <= 1'b1;
        end else if (wr_addr_low || wr_addr_high || wr_control || ee_done_i) begin
            read_pending <= 1'b1;
        end else if (issue_read) begin
            read_pending <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mem_data <= RST_MEM_DATA;
        end else if (wr_data && !erase_write_busy) begin
            mem_data <= sfr_wdata_i;
        end else if (ee_rdata_valid_i) begin
            mem_data <= ee_rdata_i;
        end
    end

    // ------------------------------------------------------------
    // Sequencer command outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ee_start_o  <= 1'b0;
            ee_read_o   <= 1'b0;
            ee_op_o     <= OP_BYTE_MODE;
            ee_addr_o   <= {RST_MEM_ADDR_HIGH, RST_MEM_ADDR_LOW};
            ee_wdata_o  <= RST_MEM_DATA;
            ee_timing_o <= RST_MEM_WRITE_TIMING;
        end else begin
            ee_start_o  <= launch;
            ee_read_o   <= issue_read;
            ee_timing_o <= mem_write_timing;
            if (launch) begin
                ee_op_o    <= eesfr_op_t'(op_select);
                ee_wdata_o <= sfr_wdata_i;
                if (op_select == OP_ROW_ERASE) begin
                    ee_addr_o <= {mem_addr_high, mem_addr_low[7:ROW_OFFSET_BITS], 3'b000};
                end else begin
                    ee_addr_o <= {mem_addr_high, mem_addr_low};
                end
            end else if (issue_read) begin
                ee_op_o   <= OP_BYTE_MODE;
                ee_addr_o <= {mem_addr_high, mem_addr_low};
            end
        end
    end

    // ------------------------------------------------------------
    // Core read-back
    // ------------------------------------------------------------
    always_comb begin
        unique case (sfr_addr_i)
            ADDR_MEM_ADDR_LOW:     next_rdata = mem_addr_low;
            ADDR_MEM_ADDR_HIGH:    next_rdata = mem_addr_high;
            ADDR_MEM_DATA:         next_rdata = mem_data;
            ADDR_MEM_WRITE_TIMING: next_rdata = mem_write_timing;
            ADDR_MEM_CONTROL:      next_rdata = ctrl_view;
            default:               next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sfr_rdata_o     <= 8'h00;
            sfr_bit_rdata_o <= 1'b0;
        end else begin
            if (sfr_rd_i) begin
                sfr_rdata_o <= next_rdata;
            end
            sfr_bit_rdata_o <= bit_hit & sfr_bit_wdata_i & sfr_bit_wr_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            forced_irq_flag_o <= 1'b0;
            mem_irq_enable_o  <= 1'b0;
        end else begin
            forced_irq_flag_o <= forced_irq_flag;
            mem_irq_enable_o  <= mem_irq_enable;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_start_one_pulse: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        ee_start_o |=> !ee_start_o)
        else $error("start pulse longer than one cycle");
    a_data_launches: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_data && !erase_write_busy && op_select == OP_BYTE_MODE) |=> ee_start_o && erase_write_busy)
        else $error("data write did not launch");
    a_busy_blocks: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (erase_write_busy && !ee_done_i) |=> erase_write_busy && !ee_start_o && !ee_read_o)
        else $error("busy dropped or access while busy");
    a_busy_core_proof: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (wr_control && !launch && !ee_done_i) |=> erase_write_busy == $past(erase_write_busy))
        else $error("core write moved busy");
    a_bit4_zero: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (sfr_rd_i && sfr_addr_i == ADDR_MEM_CONTROL) |=> !sfr_rdata_o[BIT_CTRL_UNUSED])
        else $error("unused control bit read as one");
    a_row_aligned: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (ee_start_o && ee_op_o == OP_ROW_ERASE) |-> ee_addr_o[2:0] == 3'b000)
        else $error("row erase address not row aligned");
    a_irq_en_write: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        wr_control |=> ##1 mem_irq_enable_o == $past(sfr_wdata_i[BIT_MEM_IRQ_ENABLE], 2))
        else $error("irq enable not taken from core write");
    a_readback: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        (sfr_wr_i && sfr_addr_i == ADDR_MEM_WRITE_TIMING) ##1 (sfr_rd_i && sfr_addr_i == ADDR_MEM_WRITE_TIMING
        && !sfr_wr_i) |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
        else $error("timing register read-back mismatch");
endmodule

// >>> verification/eesfr_seq_model.sv
// Behavioural model of the erase/write sequencer behind the register bank.
// Assumes one-cycle start/read pulses from the bank; answers after a fixed delay.
`timescale 1ns/10ps
module eesfr_seq_model
    import eesfr_pkg::*;
#(
    parameter int DLY = 8
) (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        ee_start_i,
    input  wire logic        ee_read_i,
    input  eesfr_pkg::eesfr_op_t ee_op_i,
    input  wire logic [15:0] ee_addr_i,
    input  wire logic [7:0]  ee_wdata_i,
    output logic             ee_done_o,
    output logic             ee_rdata_valid_o,
    output logic [7:0]       ee_rdata_o
);
    logic [7:0]  mem [256];
    eesfr_op_t   op_q;
    logic [15:0] addr_q;
    logic [7:0]  wd_q;
    int          cnt;
    // Array preset to the inverse of each address, so erases show up
    initial for (int i = 0; i < 256; i++) mem[i] = ~i[7:0];
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt <= 0;
            ee_done_o <= 1'b0;
            ee_rdata_valid_o <= 1'b0;
            ee_rdata_o <= 8'hA5;
        end else begin
            ee_done_o <= 1'b0;
            ee_rdata_valid_o <= 1'b0;
            // Released data bus keeps toggling, never holding a stale byte for two cycles
            ee_rdata_o <= ~ee_rdata_o;
            if (ee_start_i) begin
                cnt <= DLY;
                op_q <= ee_op_i;
                addr_q <= ee_addr_i;
                wd_q <= ee_wdata_i;
            end else if (cnt == 1) begin
                case (op_q)
                    OP_BYTE_MODE: mem[addr_q[7:0]] = wd_q;
                    OP_ROW_ERASE: for (int j = 0; j < 8; j++) mem[{addr_q[7:3], j[2:0]}] = 8'h00;
                    default: for (int j = 0; j < 256; j++) mem[j] = 8'h00;
                endcase
                ee_done_o <= 1'b1;
                cnt <= 0;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
            if (ee_read_i) begin
                ee_rdata_valid_o <= 1'b1;
                ee_rdata_o <= mem[ee_addr_i[7:0]];
            end
        end
    end
endmodule

// >>> verification/eesfr_top_tb.sv
// Self-checking bench for the register bank with a sequencer model behind it.
// Assumes the design's registered read data appears one cycle after the read edge.
`timescale 1ns/10ps
module eesfr_top_tb;
    import eesfr_pkg::*;
    logic core_clk, arst_n, sfr_wr, sfr_rd, bit_wr, bit_wd, bit_rd, start, rdo, done, vld;
    logic rd_q = 1'b0;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, bit_addr, wdata, timing, rdata, a1, v;
    logic [15:0] addr;
    logic forced, irq_en;
    eesfr_op_t op;
    logic [7:0] exp_q[$];
    logic [7:0] chk_a[4] = '{8'h28, 8'h2F, 8'h27, 8'h30};
    logic [7:0] chk_e[4] = '{8'h00, 8'h00, 8'hD8, 8'hCF};
    int error_cnt = 0;
    int total_checks = 0;
    eesfr_top dut (.core_clk_i(core_clk), .arst_n_i(arst_n), .sfr_addr_i(sfr_addr), .sfr_wr_i(sfr_wr),
        .sfr_wdata_i(sfr_wdata), .sfr_rd_i(sfr_rd), .sfr_rdata_o(sfr_rdata), .sfr_bit_addr_i(bit_addr),
        .sfr_bit_wr_i(bit_wr), .sfr_bit_wdata_i(bit_wd), .sfr_bit_rdata_o(bit_rd), .ee_start_o(start),
        .ee_read_o(rdo), .ee_op_o(op), .ee_addr_o(addr), .ee_wdata_o(wdata), .ee_timing_o(timing),
        .ee_done_i(done), .ee_rdata_valid_i(vld), .ee_rdata_i(rdata), .forced_irq_flag_o(forced),
        .mem_irq_enable_o(irq_en));
    eesfr_seq_model #(.DLY(8)) seq (.clk_i(core_clk), .arst_n_i(arst_n), .ee_start_i(start), .ee_read_i(rdo),
        .ee_op_i(op), .ee_addr_i(addr), .ee_wdata_i(wdata), .ee_done_o(done), .ee_rdata_valid_o(vld),
        .ee_rdata_o(rdata));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // Bus tasks and checking
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge core_clk);
        sfr_rd <= 1'b0;
    endtask
    // Write then read back on the very next edge, the tightest legal spacing
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b1;
        exp_q.push_back(d);
        @(posedge core_clk);
        sfr_rd <= 1'b0;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] e);
        total_checks++;
        if (got !== e) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    task automatic finish_test;
        if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Oldest note is matched against the data one cycle after its read edge
    always @(posedge core_clk) begin
        if (rd_q) chk8(sfr_rdata, exp_q.pop_front());
        rd_q <= sfr_rd;
    end
    initial begin
        #150000;
        error_cnt++;
        finish_test();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {arst_n, sfr_wr, sfr_rd, bit_wr, bit_wd} = '0;
        {sfr_addr, sfr_wdata, bit_addr} = '0;
        void'($urandom(6));
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        rd(ADDR_MEM_ADDR_LOW, 8'h00);
        rd(ADDR_MEM_ADDR_HIGH, 8'h80);
        rd(ADDR_MEM_WRITE_TIMING, 8'h08);
        rd(ADDR_MEM_CONTROL, 8'h00);
        foreach (chk_a[i]) begin
            v = 8'($urandom);
            wr(8'hF2 + 8'(i == 0 ? 0 : i == 1 ? 1 : 3), v);
            rd(8'hF2 + 8'(i == 0 ? 0 : i == 1 ? 1 : 3), v);
        end
        v = 8'($urandom);
        wr(ADDR_MEM_CONTROL, v | 8'h30);
        rd(ADDR_MEM_CONTROL, v & 8'hCF);
        wr(ADDR_MEM_CONTROL, 8'h40);
        // Output copy trails the register by one edge
        repeat (2) @(posedge core_clk);
        chk8({forced, irq_en, 6'h00}, 8'h40);
        rd(8'hF7, 8'h00);
        v = 8'($urandom);
        wr_rd(ADDR_MEM_WRITE_TIMING, v);
        @(posedge core_clk);
        chk8(timing, v);
        wr(ADDR_MEM_CONTROL, 8'h05);
        wr(ADDR_MEM_DATA, 8'h3C);
        rd(ADDR_MEM_CONTROL, 8'h05);
        rd(ADDR_MEM_DATA, 8'h3C);
        a1 = {3'b110, 5'($urandom)};
        v = 8'($urandom);
        wr(ADDR_MEM_ADDR_HIGH, 8'h00);
        wr(ADDR_MEM_ADDR_LOW, a1);
        @(posedge core_clk);
        bit_addr <= ADDR_MEM_ADDR_LOW;
        bit_wd <= ~a1[0];
        bit_wr <= 1'b1;
        @(posedge core_clk);
        bit_wr <= 1'b0;
        @(posedge core_clk);
        chk8({7'h00, bit_rd}, 8'h00);
        rd(ADDR_MEM_ADDR_LOW, a1);
        wr(ADDR_MEM_CONTROL, 8'h00);
        wr(ADDR_MEM_DATA, v);
        wr(ADDR_MEM_DATA, ~v);
        rd(ADDR_MEM_CONTROL, 8'h20);
        repeat (20) @(posedge core_clk);
        rd(ADDR_MEM_DATA, v);
        wr(ADDR_MEM_ADDR_LOW, 8'h2D);
        wr(ADDR_MEM_CONTROL, 8'h0C);
        wr(ADDR_MEM_DATA, 8'hFF);
        repeat (20) @(posedge core_clk);
        wr(ADDR_MEM_CONTROL, 8'h00);
        foreach (chk_a[i]) begin
            wr(ADDR_MEM_ADDR_LOW, chk_a[i]);
            repeat (6) @(posedge core_clk);
            rd(ADDR_MEM_DATA, chk_e[i]);
        end
        wr(ADDR_MEM_CONTROL, 8'h0A);
        wr(ADDR_MEM_DATA, 8'h00);
        repeat (20) @(posedge core_clk);
        wr(ADDR_MEM_CONTROL, 8'h00);
        wr(ADDR_MEM_ADDR_LOW, a1);
        repeat (6) @(posedge core_clk);
        rd(ADDR_MEM_DATA, 8'h00);
        repeat (3) @(posedge core_clk);
        finish_test();
    end
endmodule
